// ==== core/mft_pkg.sv ====
// constants, field layouts and carriers for the terminal logic block
package mft_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_TIME_US = 2000;
  localparam int SCAN_CYCLES = SCAN_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int LONG_PRESS_MS = 2000;
  localparam int LONG_TICKS = LONG_PRESS_MS * 1000 / SCAN_TIME_US;

  localparam int AW = 5;
  localparam int DW = 16;
  localparam int NIN = 6;
  localparam int FW = 16;

  // register word addresses
  localparam logic [AW-1:0] A_FSEL0 = 5'h00; // 0x00..0x05, one per input
  localparam logic [AW-1:0] A_SCAN_N = 5'h06;
  localparam logic [AW-1:0] A_POL15 = 5'h07;
  localparam logic [AW-1:0] A_POL6 = 5'h08;
  localparam logic [AW-1:0] A_STEP = 5'h09;
  localparam logic [AW-1:0] A_HOLD = 5'h0a;
  localparam logic [AW-1:0] A_SRC = 5'h0b;
  localparam logic [AW-1:0] A_STOPM = 5'h0c;
  localparam logic [AW-1:0] A_UPPER = 5'h0d;
  localparam logic [AW-1:0] A_LOWER = 5'h0e;
  localparam logic [AW-1:0] A_PRESET0 = 5'h0f;
  localparam logic [AW-1:0] A_RELAY_F = 5'h10;
  localparam logic [AW-1:0] A_TRANS_F = 5'h11;
  localparam logic [AW-1:0] A_REACH = 5'h12;
  localparam logic [AW-1:0] A_BAND = 5'h13;
  localparam logic [AW-1:0] A_RAMP = 5'h14;
  localparam logic [AW-1:0] A_STATUS = 5'h18;
  localparam logic [AW-1:0] A_SETPT = 5'h19;

  // reset values
  localparam logic [7:0] RST_SCAN_N = 8'h01;
  localparam logic [FW-1:0] RST_UPPER = 16'h9c40;
  localparam logic [FW-1:0] RST_RAMP = 16'h0001;
  localparam logic [4:0] RST_FSEL [NIN] = '{5'h00, 5'h01, 5'h02, 5'h03,
                                             5'h0f, 5'h10};

  // input function codes
  localparam logic [4:0] FN_UP = 5'h0f;
  localparam logic [4:0] FN_DOWN = 5'h10;
  localparam logic [4:0] FN_SRC_SEL = 5'h11;
  localparam logic [4:0] FN_PID_OFF = 5'h12;
  localparam logic [4:0] FN_PID_ICLR = 5'h13;
  localparam logic [4:0] FN_FLT_RST = 5'h14;

  localparam logic [2:0] SRC_UPDOWN = 3'h3;
  localparam int SRC_SUB_LSB = 3;

  typedef enum logic [1:0] {
    HOLD_KEEP_IDLE = 2'b00,
    HOLD_ZERO = 2'b01,
    HOLD_KEEP_ACTIVE = 2'b10
  } mft_hold_t;

  typedef enum logic [3:0] {
    OF_RUN = 4'h0, OF_FAULT = 4'h1, OF_REACHED = 4'h2, OF_AT_LEVEL = 4'h3,
    OF_ABOVE = 4'h4, OF_BELOW = 4'h5, OF_RESTART = 4'h6, OF_PWR_LOSS = 4'h7,
    OF_ESTOP = 4'h8, OF_BBLOCK = 4'h9, OF_MOT_OVL = 4'ha, OF_DRV_OVL = 4'hb,
    OF_OVERTRQ = 4'hc, OF_PID_LOSS = 4'hd
  } mft_ofunc_t;

  typedef struct packed {
    logic fault;
    logic restart;
    logic pwr_loss;
    logic estop;
    logic bblock;
    logic mot_ovl;
    logic drv_ovl;
    logic overtrq;
    logic pid_loss;
  } mft_drv_status_t;

  typedef struct packed {
    logic sub_src_sel;
    logic updown_src;
    logic pid_disable;
    logic pid_int_clear;
    logic fault_reset;
    logic coast_stop;
  } mft_cmd_t;
endpackage : mft_pkg

// ==== core/mft_terminal.sv ====
// multifunction terminal inputs, up/down setpoint and digital outputs
//
// Function
// - up/down acts only when the selected frequency source equals 3.
// - hold mode 0 starts from preset zero; up/down ramps, release holds.
// - holding modes store the stop-time setpoint back into preset zero.
// - hold mode 0 ignores up and down while stopped.
// - hold mode 2 keeps setpoint and accepts up/down while stopped.
// - hold mode 1 clears setpoint to zero at stop and start.
// - stop during up/down ramps or coasts per stop-method setting.
// - up and down together are ignored; setpoint unchanged.
// - nonzero step size moves setpoint one step per assertion.
// - stepped input held over 2 s switches to continuous ramping.
// - zero step size ramps continuously while up or down is held.
// - up/down steps and preset starts are clamped between lower and upper limits.
// - function 17 selects main source when off, sub source when on.
// - function 18 disables the PID function while on.
// - function 19 clears the PID integrator while on.
// - function 20 is a fault reset; nothing happens while off.
// - inputs sampled every 2 ms, accepted after N equal samples.
// - relay and transistor outputs each select function 0 to 13.
// - function 2 asserts when output frequency is near command.
// - function 3 asserts when output frequency is near reach level.
// - function 4 asserts above reach level, function 5 below it.
// - five polarity bits for inputs one to five, one for six.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
module mft_terminal #(
  parameter int SCAN_CYC = mft_pkg::SCAN_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [mft_pkg::AW-1:0] i_addr,
  input wire logic [mft_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [mft_pkg::DW-1:0] o_rdata,
  input wire logic [mft_pkg::NIN-1:0] i_multifunction_inputs,
  input wire logic i_run,
  input wire logic i_running,
  input wire logic [mft_pkg::FW-1:0] i_out_freq,
  input wire logic [mft_pkg::FW-1:0] i_cmd_freq,
  input wire mft_pkg::mft_drv_status_t i_drv_status,
  output logic [mft_pkg::FW-1:0] o_setpoint,
  output mft_pkg::mft_cmd_t o_cmd,
  output logic o_relay_output_one,
  output logic o_transistor_output_one
);
  logic [4:0] fsel [mft_pkg::NIN];
  logic [7:0] scan_n;
  logic [4:0] pol15;
  logic pol6;
  logic [mft_pkg::FW-1:0] step, upper, lower, preset0, reach, band, ramp;
  mft_pkg::mft_hold_t hold;
  logic [5:0] src;
  logic stop_coast;
  logic [3:0] relay_f, trans_f;
  logic [31:0] scan_cnt;
  logic [mft_pkg::NIN-1:0] stable, up_dn_q;
  logic [7:0] db_cnt [mft_pkg::NIN];
  logic [9:0] held;
  logic run_q, up_q, dn_q;
  logic [mft_pkg::FW-1:0] setpoint, next_setpoint;

  wire tick = (scan_cnt == 32'(SCAN_CYC - 1));
  wire [mft_pkg::NIN-1:0] pol = {pol6, pol15};
  wire [mft_pkg::NIN-1:0] level = i_multifunction_inputs ^ pol;

  function automatic logic fn_on(input logic [4:0] code,
      input logic [4:0] sel [mft_pkg::NIN], input logic [5:0] st);
    logic r;
    r = 1'b0;
    for (int k = 0; k < mft_pkg::NIN; k++) begin
      r = r | (st[k] & (sel[k] == code));
    end
    return r;
  endfunction : fn_on
  function automatic logic [mft_pkg::FW-1:0] absdiff(
      input logic [mft_pkg::FW-1:0] a, input logic [mft_pkg::FW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff
  function automatic logic [mft_pkg::FW-1:0] clamp(input logic [16:0] v,
      input logic neg, input logic [mft_pkg::FW-1:0] lo,
      input logic [mft_pkg::FW-1:0] hi);
    logic [mft_pkg::FW-1:0] r;
    r = v[mft_pkg::FW-1:0];
    if (neg | (v[mft_pkg::FW-1:0] < lo)) begin
      r = lo;
    end else if (v[16] | (v[mft_pkg::FW-1:0] > hi)) begin
      r = hi;
    end
    return r;
  endfunction : clamp
  // decoded terminal functions
  wire f_up = fn_on(mft_pkg::FN_UP, fsel, stable);
  wire f_dn = fn_on(mft_pkg::FN_DOWN, fsel, stable);
  wire f_sub = fn_on(mft_pkg::FN_SRC_SEL, fsel, stable);
  wire [2:0] act_src = f_sub ? src[5:mft_pkg::SRC_SUB_LSB] :
      src[2:0];
  wire ud_src = (act_src == mft_pkg::SRC_UPDOWN);
  wire run_rise = i_run & ~run_q;
  wire run_fall = ~i_run & run_q;
  wire ud_live = ud_src &
      (i_run | (hold == mft_pkg::HOLD_KEEP_ACTIVE));
  wire one_key = f_up ^ f_dn;
  wire ud_step_en = ud_live & tick & one_key;
  wire key_rise = (f_up & ~up_q) | (f_dn & ~dn_q);
  wire stepped = (step != '0);
  wire long_held = (held >= 10'(mft_pkg::LONG_TICKS));
  // a stepped key moves once on press, then ramps after the long hold
  wire [mft_pkg::FW-1:0] delta = (stepped & key_rise) ? step :
      ((~stepped | long_held) ? ramp : '0);
  wire [16:0] sum_up = {1'b0, setpoint} + {1'b0, delta};
  wire [16:0] sum_dn = {1'b0, setpoint} - {1'b0, delta};

  always_comb begin
    next_setpoint = setpoint;
    if (run_rise & ud_src) begin
      next_setpoint = (hold == mft_pkg::HOLD_ZERO) ? '0 :
          clamp({1'b0, preset0}, 1'b0, lower, upper);
    end else if (run_fall & ud_src & (hold == mft_pkg::HOLD_ZERO)) begin
      next_setpoint = '0;
    end else if (ud_step_en) begin
      next_setpoint = f_up ? clamp(sum_up, 1'b0, lower, upper) :
          clamp(sum_dn, sum_dn[16], lower, upper);
    end
  end

  // debounce on the 2 ms scan; scan counter runs every clock, debounce counters only on ticks
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scan_cnt <= '0;
    end else begin
      scan_cnt <= tick ? '0 : scan_cnt + 32'h1;
    end
  end
  for (genvar k = 0; k < mft_pkg::NIN; k++) begin : g_db
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        stable[k] <= 1'b0;
        db_cnt[k] <= '0;
      end else if (tick) begin
        if (level[k] == stable[k]) begin
          db_cnt[k] <= '0;
        end else if (db_cnt[k] + 8'h1 >= scan_n) begin
          stable[k] <= level[k];
          db_cnt[k] <= '0;
        end else begin
          db_cnt[k] <= db_cnt[k] + 8'h1;
        end
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      held <= '0;
    end else if (tick) begin
      up_q <= f_up;
      dn_q <= f_dn;
      if (!one_key) begin
        held <= '0;
      end else if (!long_held) begin
        held <= held + 10'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      setpoint <= '0;
    end else begin
      run_q <= i_run;
      setpoint <= next_setpoint;
    end
  end

  // register writes; the stop-time store beats a same-cycle software write
  wire store_pre = run_fall & ud_src & (hold != mft_pkg::HOLD_ZERO);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < mft_pkg::NIN; k++) begin
        fsel[k] <= mft_pkg::RST_FSEL[k];
      end
      scan_n <= mft_pkg::RST_SCAN_N;
      pol15 <= '0;
      pol6 <= 1'b0;
      step <= '0;
      hold <= mft_pkg::HOLD_KEEP_IDLE;
      src <= '0;
      stop_coast <= 1'b0;
      upper <= mft_pkg::RST_UPPER;
      lower <= '0;
      preset0 <= '0;
      relay_f <= '0;
      trans_f <= '0;
      reach <= '0;
      band <= '0;
      ramp <= mft_pkg::RST_RAMP;
    end else begin
      if (i_wr) begin
        for (int k = 0; k < mft_pkg::NIN; k++) begin
          if (i_addr == mft_pkg::A_FSEL0 + 5'(k)) begin
            fsel[k] <= i_wdata[4:0];
          end
        end
        case (i_addr)
          mft_pkg::A_SCAN_N: scan_n <= (i_wdata[7:0] == '0) ?
              mft_pkg::RST_SCAN_N : i_wdata[7:0];
          mft_pkg::A_POL15: pol15 <= i_wdata[4:0];
          mft_pkg::A_POL6: pol6 <= i_wdata[0];
          mft_pkg::A_STEP: step <= i_wdata;
          mft_pkg::A_HOLD: hold <= mft_pkg::mft_hold_t'(i_wdata[1:0]);
          mft_pkg::A_SRC: src <= i_wdata[5:0];
          mft_pkg::A_STOPM: stop_coast <= i_wdata[0];
          mft_pkg::A_UPPER: upper <= i_wdata;
          mft_pkg::A_LOWER: lower <= i_wdata;
          mft_pkg::A_PRESET0: preset0 <= i_wdata;
          mft_pkg::A_RELAY_F: relay_f <= i_wdata[3:0];
          mft_pkg::A_TRANS_F: trans_f <= i_wdata[3:0];
          mft_pkg::A_REACH: reach <= i_wdata;
          mft_pkg::A_BAND: band <= i_wdata;
          mft_pkg::A_RAMP: ramp <= i_wdata;
          default: ;
        endcase
      end
      if (store_pre) begin
        preset0 <= setpoint;
      end
    end
  end

  // read mux; unmapped words read zero
  logic [mft_pkg::DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (i_addr < mft_pkg::A_FSEL0 + 5'(mft_pkg::NIN)) begin
      rd_mux = {11'h0, fsel[i_addr[2:0]]};
    end
    case (i_addr)
      mft_pkg::A_SCAN_N: rd_mux = {8'h0, scan_n};
      mft_pkg::A_POL15: rd_mux = {11'h0, pol15};
      mft_pkg::A_POL6: rd_mux = {15'h0, pol6};
      mft_pkg::A_STEP: rd_mux = step;
      mft_pkg::A_HOLD: rd_mux = {14'h0, hold};
      mft_pkg::A_SRC: rd_mux = {10'h0, src};
      mft_pkg::A_STOPM: rd_mux = {15'h0, stop_coast};
      mft_pkg::A_UPPER: rd_mux = upper;
      mft_pkg::A_LOWER: rd_mux = lower;
      mft_pkg::A_PRESET0: rd_mux = preset0;
      mft_pkg::A_RELAY_F: rd_mux = {12'h0, relay_f};
      mft_pkg::A_TRANS_F: rd_mux = {12'h0, trans_f};
      mft_pkg::A_REACH: rd_mux = reach;
      mft_pkg::A_BAND: rd_mux = band;
      mft_pkg::A_RAMP: rd_mux = ramp;
      mft_pkg::A_STATUS: rd_mux = {8'h0, o_transistor_output_one,
          o_relay_output_one, stable};
      mft_pkg::A_SETPT: rd_mux = setpoint;
      default: ;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // output drive conditions
  function automatic logic out_sel(input logic [3:0] f,
      input logic [mft_pkg::FW-1:0] fo, input logic [mft_pkg::FW-1:0] fc,
      input logic [mft_pkg::FW-1:0] lv, input logic [mft_pkg::FW-1:0] bd,
      input logic run, input mft_pkg::mft_drv_status_t s);
    logic r;
    case (mft_pkg::mft_ofunc_t'(f))
      mft_pkg::OF_RUN: r = run;
      mft_pkg::OF_FAULT: r = s.fault;
      mft_pkg::OF_REACHED: r = absdiff(fo, fc) <= bd;
      mft_pkg::OF_AT_LEVEL: r = absdiff(fo, lv) <= bd;
      mft_pkg::OF_ABOVE: r = fo > lv;
      mft_pkg::OF_BELOW: r = fo < lv;
      mft_pkg::OF_RESTART: r = s.restart;
      mft_pkg::OF_PWR_LOSS: r = s.pwr_loss;
      mft_pkg::OF_ESTOP: r = s.estop;
      mft_pkg::OF_BBLOCK: r = s.bblock;
      mft_pkg::OF_MOT_OVL: r = s.mot_ovl;
      mft_pkg::OF_DRV_OVL: r = s.drv_ovl;
      mft_pkg::OF_OVERTRQ: r = s.overtrq;
      mft_pkg::OF_PID_LOSS: r = s.pid_loss;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : out_sel

  mft_pkg::mft_cmd_t next_cmd;
  always_comb begin
    next_cmd.sub_src_sel = f_sub;
    next_cmd.updown_src = ud_src;
    next_cmd.pid_disable = fn_on(mft_pkg::FN_PID_OFF, fsel, stable);
    next_cmd.pid_int_clear =
        fn_on(mft_pkg::FN_PID_ICLR, fsel, stable);
    next_cmd.fault_reset = fn_on(mft_pkg::FN_FLT_RST, fsel, stable);
    next_cmd.coast_stop = stop_coast;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd <= '0;
      o_relay_output_one <= 1'b0;
      o_transistor_output_one <= 1'b0;
    end else begin
      o_cmd <= next_cmd;
      o_relay_output_one <= out_sel(relay_f, i_out_freq, i_cmd_freq,
          reach, band, i_running, i_drv_status);
      o_transistor_output_one <= out_sel(trans_f, i_out_freq, i_cmd_freq,
          reach, band, i_running, i_drv_status);
    end
  end

  assign o_setpoint = setpoint;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_both_ignored: assert property (
    (tick && f_up && f_dn && !run_rise && !run_fall) |=> $stable(setpoint))
    else $error("setpoint moved with up and down both on");
  chk_idle_frozen: assert property (
    (hold == mft_pkg::HOLD_KEEP_IDLE && !i_run) |=> $stable(setpoint))
    else $error("setpoint moved while stopped in hold mode 0");
  chk_ud_clamped: assert property (
    (ud_step_en && !run_rise) |=> (setpoint <= upper && setpoint >= lower))
    else $error("up/down setpoint outside limits");
  chk_zero_start: assert property (
    (run_rise && ud_src && hold == mft_pkg::HOLD_ZERO) |=> setpoint == '0)
    else $error("hold mode 1 run did not start at zero");
  chk_stop_store: assert property (
    store_pre |=> preset0 == $past(setpoint))
    else $error("stop-time frequency not stored");
  chk_scan_only: assert property (
    $changed(stable) |-> $past(tick))
    else $error("debounced input changed off the scan tick");
  chk_pid_off: assert property (
    fn_on(mft_pkg::FN_PID_OFF, fsel, stable) |=> o_cmd.pid_disable)
    else $error("pid disable not driven");
  chk_src_pick: assert property (
    (f_sub && src[5:3] == mft_pkg::SRC_UPDOWN) |=> o_cmd.updown_src)
    else $error("sub source not selected");
  chk_relay_run: assert property (
    (relay_f == 4'h0) |=> o_relay_output_one == $past(i_running))
    else $error("relay run function wrong");
  chk_step_once: assert property (
    (ud_step_en && stepped && key_rise && f_up && !run_rise
     && sum_up <= 17'(upper) && setpoint >= lower)
     |=> setpoint == $past(setpoint) + $past(step))
    else $error("step size not applied");

  cov_run_start: cover property (run_rise && ud_src);
  cov_long_ramp: cover property (ud_step_en && stepped && long_held);
  cov_relay_on: cover property (o_relay_output_one);
  cov_stop_store: cover property (store_pre);
endmodule : mft_terminal

// ==== tb/mft_contacts.sv ====
// contact model standing on the six terminal inputs
`timescale 1ns/10ps
module mft_contacts (
  input wire logic [5:0] i_press,
  input wire logic [5:0] i_nc,
  output logic [5:0] o_pins
);
  // a pressed normally-closed contact opens the circuit
  assign o_pins = i_press ^ i_nc;
endmodule : mft_contacts

// ==== tb/multifunction_terminal_logic_bench.sv ====
// self-checking bench for the terminal logic block
`timescale 1ns/10ps
module multifunction_terminal_logic_bench;
  localparam int SC = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = '0;
  logic [15:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [5:0] press = '0;
  logic [5:0] nc = '0;
  logic [5:0] pins;
  logic run = 1'b0;
  logic running = 1'b0;
  logic [15:0] fout = '0;
  logic [15:0] fcmd = '0;
  mft_pkg::mft_drv_status_t st = '0;
  logic [15:0] setpt;
  mft_pkg::mft_cmd_t cmd;
  logic relay;
  logic trans;
  logic [15:0] sv;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  mft_contacts contacts (.i_press(press), .i_nc(nc), .o_pins(pins));

  mft_terminal #(.SCAN_CYC(SC)) DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_multifunction_inputs(pins),
    .i_run(run), .i_running(running), .i_out_freq(fout),
    .i_cmd_freq(fcmd), .i_drv_status(st), .o_setpoint(setpt),
    .o_cmd(cmd), .o_relay_output_one(relay),
    .o_transistor_output_one(trans)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t in %s: got %h expected %h", $time, what,
               got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic ticks(input int n);
    cyc(n * SC);
  endtask : ticks

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp,
                        input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp, what);
  endtask : rd_chk

  task automatic set(input logic [5:0] v);
    @(posedge clk);
    press <= v;
  endtask : set

  task automatic tap(input logic [5:0] b, input int n);
    set(press | b);
    ticks(n);
    set(press & ~b);
    ticks(n);
  endtask : tap

  task automatic set_run(input logic v);
    @(posedge clk);
    run <= v;
    cyc(3);
  endtask : set_run

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd_chk(5'(i), 16'(mft_pkg::RST_FSEL[i]), "fsel");
    end
    rd_chk(mft_pkg::A_SCAN_N, 16'h0001, "scan");
    rd_chk(mft_pkg::A_UPPER, 16'h9c40, "upper");
    rd_chk(5'h15, 16'h0000, "unmapped");
    wr_reg(mft_pkg::A_STATUS, 16'h00ff);
    rd_chk(mft_pkg::A_STATUS, 16'h0000, "status");
    $display("test reset done");
  endtask : t_reset

  task automatic t_inputs;
    wr_reg(mft_pkg::A_SCAN_N, 16'h0003);
    for (int i = 0; i < 4; i++) wr_reg(5'(i), 16'(17 + i));
    wr_reg(mft_pkg::A_POL15, 16'h0001);
    wr_reg(mft_pkg::A_POL6, 16'h0001);
    nc <= 6'h21;
    ticks(6);
    rd_chk(mft_pkg::A_STATUS, 16'h0000, "nc idle");
    // at most two ticks of chatter, whatever the phase, below three
    set(6'h0f);
    ticks(1);
    set(6'h00);
    ticks(5);
    check({12'h0, cmd[5], cmd[3:1]}, 16'h0000, "chatter");
    set(6'h0f);
    ticks(5);
    rd_chk(mft_pkg::A_STATUS, 16'h000f, "pressed");
    check({12'h0, cmd.sub_src_sel, cmd.pid_disable, cmd.pid_int_clear,
           cmd.fault_reset}, 16'h000f, "functions");
    set(6'h00);
    ticks(5);
    check({12'h0, cmd[5], cmd[3:1]}, 16'h0000, "released");
    wr_reg(mft_pkg::A_SCAN_N, 16'h0001);
    wr_reg(mft_pkg::A_POL15, 16'h0000);
    wr_reg(mft_pkg::A_POL6, 16'h0000);
    nc <= 6'h00;
    ticks(3);
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_stepped;
    wr_reg(mft_pkg::A_SRC, 16'h0018);
    wr_reg(mft_pkg::A_STEP, 16'h0005);
    wr_reg(mft_pkg::A_PRESET0, 16'h03e8);
    set(6'h01);
    ticks(3);
    check({15'h0, cmd.updown_src}, 16'h0001, "source");
    set_run(1'b1);
    check(setpt, 16'h03e8, "start");
    tap(6'h10, 2);
    tap(6'h10, 2);
    check(setpt, 16'h03f2, "up step");
    tap(6'h20, 2);
    check(setpt, 16'h03ed, "down step");
    tap(6'h30, 2);
    check(setpt, 16'h03ed, "both");
    set(6'h00);
    ticks(2);
    tap(6'h10, 2);
    check(setpt, 16'h03ed, "main src");
    set(6'h01);
    ticks(2);
    set_run(1'b0);
    rd_chk(mft_pkg::A_PRESET0, 16'h03ed, "stored");
    sv = setpt;
    tap(6'h10, 2);
    check(setpt, sv, "stopped");
    $display("test stepped done");
  endtask : t_stepped

  task automatic t_ramp;
    wr_reg(mft_pkg::A_HOLD, 16'h0001);
    wr_reg(mft_pkg::A_STEP, 16'h0000);
    wr_reg(mft_pkg::A_RAMP, 16'h0007);
    wr_reg(mft_pkg::A_UPPER, 16'h0064);
    wr_reg(mft_pkg::A_LOWER, 16'h0003);
    wr_reg(mft_pkg::A_STOPM, 16'h0001);
    cyc(2);
    check({15'h0, cmd.coast_stop}, 16'h0001, "coast");
    wr_reg(mft_pkg::A_STOPM, 16'h0000);
    cyc(2);
    check({15'h0, cmd.coast_stop}, 16'h0000, "ramp stop");
    set_run(1'b1);
    check(setpt, 16'h0000, "from zero");
    tap(6'h10, 20);
    check(setpt, 16'h0064, "upper");
    tap(6'h20, 20);
    check(setpt, 16'h0003, "lower");
    set_run(1'b0);
    check(setpt, 16'h0000, "cleared");
    $display("test ramp done");
  endtask : t_ramp

  task automatic t_hold2;
    wr_reg(mft_pkg::A_HOLD, 16'h0002);
    wr_reg(mft_pkg::A_STEP, 16'h0001);
    wr_reg(mft_pkg::A_RAMP, 16'h0002);
    wr_reg(mft_pkg::A_UPPER, 16'h9c40);
    wr_reg(mft_pkg::A_LOWER, 16'h0000);
    wr_reg(mft_pkg::A_PRESET0, 16'h0032);
    set_run(1'b1);
    set_run(1'b0);
    check(setpt, 16'h0032, "kept");
    tap(6'h10, 2);
    check(setpt, 16'h0033, "idle up");
    // long press: stepped for 1000 scan ticks, then ramping
    set(6'h11);
    ticks(900);
    check(setpt, 16'h0034, "short hold");
    rd_chk(mft_pkg::A_SETPT, 16'h0034, "setpoint reg");
    ticks(200);
    check({15'h0, setpt > 16'd60 && setpt <= 16'd260}, 16'h0001,
          "long hold");
    set(6'h01);
    ticks(2);
    $display("test hold done");
  endtask : t_hold2

  function automatic logic exp_out(input int code, input int cond);
    if (code > 13) return 1'b0;
    if (code == 2 || code == 5) return cond == 1;
    return cond == 0;
  endfunction : exp_out

  task automatic t_outputs;
    wr_reg(mft_pkg::A_REACH, 16'h03e8);
    wr_reg(mft_pkg::A_BAND, 16'h0032);
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      fcmd <= 16'h0384;
      fout <= (c == 1) ? 16'h0384 : 16'h03fc;
      running <= (c == 0);
      st <= (c == 0) ? '1 : '0;
      for (int f = 0; f < 16; f++) begin
        wr_reg(mft_pkg::A_RELAY_F, 16'(f));
        wr_reg(mft_pkg::A_TRANS_F, 16'(f));
        cyc(2);
        check({14'h0, relay, trans}, {14'h0, {2{exp_out(f, c)}}},
              "outputs");
      end
    end
    $display("test outputs done");
  endtask : t_outputs

  initial begin
    cyc(3);
    rst_n <= 1'b1;
    t_reset;
    t_inputs;
    t_stepped;
    t_ramp;
    t_hold2;
    t_outputs;
    print_verdict;
  end

  // about three times the expected run length
  initial begin
    #400000;
    n_mismatch++;
    print_verdict;
  end
endmodule : multifunction_terminal_logic_bench
